// [verilog/edc_ctrl.sv]
// edo page-mode dram controller: strobes, address mux, refresh, write fifo
// Operation
// - wait 200 us, then eight refreshes
// - repeat wake-up after refresh overrun
// - precharge both strobes to clear output
// - we before cas gives early write; the code drops we in the same cycle as cas
// - read-write needs write delays met
// - late write: gate high, we after cas
// - never tie output gate low permanently
// - falling we is the write command
// - gate high during write keeps outputs open
// - write data timed from cas or we
// - hidden refresh after write keeps we low
// - page cycle time met both edge pairs
// - meet read hold from row or column
// - each column strobe meets pulse width
// - long address delay: address access governs
// - 1024 refreshes every 16 ms
`timescale 1ns/10ps
`include "edc_cfg.svh"
module edc_ctrl
  import edc_pkg::*;
#(
  parameter int WAKE_CYC = `EDC_WAKE_CYC,
  parameter int REF_INT  = `EDC_REF_INT_CYC
) (
  // clock and reset
  input  wire logic              CLK_SYS,
  input  wire logic              SYS_RST,
  // write request stream (address, data, byte enables)
  input  wire logic              WR_VALID,
  output logic                   WR_READY,
  input  wire edc_pkg::edc_addr_t WR_ADDR,
  input  wire edc_pkg::edc_data_t WR_DATA,
  input  wire logic [1:0]        WR_BE,
  // read request and answer
  input  wire logic              RD_VALID,
  output logic                   RD_READY,
  input  wire edc_pkg::edc_addr_t RD_ADDR,
  output logic                   RD_DONE,
  output edc_pkg::edc_data_t     RD_DATA,
  // status
  output logic                   INIT_DONE,
  // dram pins
  output logic                   ROW_STROBE_N,
  output logic                   LOWER_BYTE_COLUMN_STROBE_N,
  output logic                   UPPER_BYTE_COLUMN_STROBE_N,
  output logic                   WRITE_STROBE_N,
  output logic                   OUTPUT_GATE_N,
  output edc_pkg::edc_pin_a_t    MULTIPLEXED_ADDRESS_PINS,
  input  wire edc_pkg::edc_data_t DQ_I,
  output edc_pkg::edc_data_t     DQ_O,
  output logic                   DQ_OE
);
  import edc_pkg::*;

  localparam int FW = `EDC_ADDR_W + `EDC_DATA_W + 2;

  // controller state in one struct, apart from the data pin synchroniser flops
  typedef struct packed {
    edc_state_t st;
    edc_cnt_t   wait_cnt;      // power-up pause counter
    logic [3:0] wake_refs;     // refreshes still owed for wake-up
    logic       ready;         // wake-up complete
    edc_cnt_t   t;             // phase timer
    logic       is_wr;
    logic       is_ref;
    edc_addr_t  addr;
    edc_data_t  wdata;
    logic [1:0] be;
    logic       ras_n;
    logic       lower_byte_column_strobe_n_n;
    logic       upper_byte_column_strobe_n_n;
    logic       we_n;
    logic       oe_n;
    edc_pin_a_t a;
    edc_data_t  dq_o;
    logic       dq_oe;
    edc_data_t  rdata;
    logic       rdone;
  } edc_st_t;
  edc_st_t st_q;
  edc_st_t st_d;

  // synchronised data pins
  edc_data_t dq_s1_q;
  edc_data_t dq_s2_q;

  // fifo and timer wires
  logic                  f_valid;
  logic                  f_ready;
  logic [FW-1:0]         f_data;
  logic                  ref_req;
  logic                  ref_ovr;
  logic                  ref_ack;
  logic                  rd_take;

  // row and column halves of the word address
  function automatic edc_pin_a_t row_of(input edc_addr_t a);
    row_of = a[`EDC_ADDR_W-1:`EDC_ROW_LSB];
  endfunction : row_of
  function automatic edc_pin_a_t col_of(input edc_addr_t a);
    col_of = a[`EDC_ROW_LSB-1:0];
  endfunction : col_of

  // write requests buffered so bursts of up to eight do not stall the source
  edc_fifo #(
    .WIDTH (FW),
    .DEPTH (`EDC_FIFO_DEPTH)
  ) u_wfifo (
    .clk       (CLK_SYS),
    .rst       (SYS_RST),
    .in_valid  (WR_VALID),
    .in_ready  (WR_READY),
    .in_data   ({WR_ADDR, WR_DATA, WR_BE}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_data)
  );

  edc_refresh_timer #(
    .INTERVAL (REF_INT)
  ) u_rtimer (
    .clk     (CLK_SYS),
    .rst     (SYS_RST),
    .run     (st_q.ready),
    .ack     (ref_ack),
    .req     (ref_req),
    .overrun (ref_ovr)
  );

  // pin outputs straight from flops
  assign ROW_STROBE_N               = st_q.ras_n;
  assign LOWER_BYTE_COLUMN_STROBE_N = st_q.lower_byte_column_strobe_n_n;
  assign UPPER_BYTE_COLUMN_STROBE_N = st_q.upper_byte_column_strobe_n_n;
  assign WRITE_STROBE_N             = st_q.we_n;
  assign OUTPUT_GATE_N              = st_q.oe_n;
  assign MULTIPLEXED_ADDRESS_PINS   = st_q.a;
  assign DQ_O                       = st_q.dq_o;
  assign DQ_OE                      = st_q.dq_oe;
  assign RD_DATA                    = st_q.rdata;
  assign RD_DONE                    = st_q.rdone;
  assign INIT_DONE                  = st_q.ready;

  // reads win over writes only when no refresh is owed
  assign rd_take  = (st_q.st == EDC_IDLE) && st_q.ready && !ref_req && RD_VALID;
  assign RD_READY = rd_take;
  assign f_ready  = (st_q.st == EDC_IDLE) && st_q.ready && !ref_req && !RD_VALID;
  assign ref_ack  = (st_q.st == EDC_IDLE) && ref_req && st_q.ready;

  // data pin synchroniser, second flop alone feeds the capture
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      dq_s1_q <= '0;
      dq_s2_q <= '0;
    end
    else
    begin
      dq_s1_q <= DQ_I;
      dq_s2_q <= dq_s1_q;
    end
  end

  // sequencer next state
  always_comb
  begin
    st_d       = st_q;
    st_d.rdone = 1'b0;
    st_d.t     = (st_q.t != '0) ? st_q.t - 1'b1 : '0;
    unique case (st_q.st)
      EDC_WAKE:
      begin
        if (st_q.wait_cnt == edc_cnt_t'(WAKE_CYC - 1))
        begin
          st_d.st        = EDC_IDLE;
          st_d.wake_refs = `EDC_WAKE_REFS;
        end
        else
          st_d.wait_cnt = st_q.wait_cnt + 1'b1;
      end
      EDC_IDLE:
      begin
        // overrun drops back into the wake-up refreshes
        if (ref_ovr)
        begin
          st_d.ready     = 1'b0;
          st_d.wake_refs = `EDC_WAKE_REFS;
        end
        else if (!st_q.ready || ref_req)
        begin
          // refresh only from idle, never hidden
          st_d.is_ref = 1'b1;
          st_d.lower_byte_column_strobe_n_n = 1'b0;
          st_d.upper_byte_column_strobe_n_n = 1'b0;
          st_d.t      = edc_cnt_t'(`EDC_T_CSR_CYC);
          st_d.st     = EDC_CBR_SET;
        end
        else if (rd_take || f_valid)
        begin
          st_d.is_ref = 1'b0;
          st_d.is_wr  = !rd_take;
          st_d.addr   = rd_take ? RD_ADDR : f_data[FW-1 -: `EDC_ADDR_W];
          st_d.wdata  = f_data[2 +: `EDC_DATA_W];
          st_d.be     = rd_take ? 2'h3 : f_data[1:0];
          // row half on the pins at row strobe fall
          st_d.a      = row_of(st_d.addr);
          st_d.ras_n  = 1'b0;
          st_d.t      = edc_cnt_t'(`EDC_T_RCD_CYC);
          st_d.st     = EDC_ROW;
        end
      end
      EDC_ROW:
      begin
        // column half set up two cycles ahead of the column strobe
        // column address leads cas
        st_d.a = col_of(st_q.addr);
        if (st_q.t == '0)
        begin
          if (st_q.is_wr)
          begin
            // no late write, we with cas
            // write strobe falls with the column strobe: early write
            // the falling write strobe is the command
            st_d.we_n  = 1'b0;
            // data driven in the same cycle the column strobe falls
            st_d.dq_o  = st_q.wdata;
            st_d.dq_oe = 1'b1;
            st_d.oe_n  = 1'b1;
          end
          else
          begin
            st_d.oe_n = 1'b0;
          end
          // byte lanes follow the strobe pair
          st_d.lower_byte_column_strobe_n_n = !st_q.be[0];
          st_d.upper_byte_column_strobe_n_n = !st_q.be[1];
          st_d.t      = edc_cnt_t'(`EDC_T_CAS_CYC);
          st_d.st     = EDC_COL;
        end
      end
      EDC_COL:
      begin
        // each low column strobe held the full pulse width
        if (st_q.t == '0)
        begin
          if (!st_q.is_wr)
          begin
            st_d.rdata = dq_s2_q;
            st_d.rdone = 1'b1;
          end
          // read hold: write strobe stays high past cas rise
          st_d.lower_byte_column_strobe_n_n = 1'b1;
          st_d.upper_byte_column_strobe_n_n = 1'b1;
          st_d.we_n   = 1'b1;
          st_d.oe_n   = 1'b1;
          st_d.dq_oe  = 1'b0;
          st_d.t      = edc_cnt_t'(`EDC_T_RAS_CYC);
          st_d.st     = EDC_CAS_HI;
        end
      end
      EDC_CAS_HI:
      begin
        // column precharge before the row strobe rises
        if (st_q.t == '0)
        begin
          st_d.ras_n = 1'b1;
          st_d.t     = edc_cnt_t'(`EDC_T_RP_CYC);
          st_d.st    = EDC_PRECH;
        end
      end
      EDC_CBR_SET:
      begin
        if (st_q.t == '0)
        begin
          st_d.ras_n = 1'b0;
          st_d.t     = edc_cnt_t'(`EDC_T_RAS_CYC);
          st_d.st    = EDC_CBR_RAS;
        end
      end
      EDC_CBR_RAS:
      begin
        if (st_q.t == '0)
        begin
          // both strobes high to clear the output buffer
          st_d.ras_n  = 1'b1;
          st_d.lower_byte_column_strobe_n_n = 1'b1;
          st_d.upper_byte_column_strobe_n_n = 1'b1;
          st_d.t      = edc_cnt_t'(`EDC_T_RP_CYC);
          st_d.st     = EDC_PRECH;
          if (!st_q.ready)
          begin
            st_d.wake_refs = st_q.wake_refs - 4'h1;
            if (st_q.wake_refs == 4'h1)
              st_d.ready = 1'b1;
          end
        end
      end
      EDC_PRECH:
      begin
        if (st_q.t == '0)
          st_d.st = EDC_IDLE;
      end
      default:
        st_d.st = EDC_IDLE;
    endcase
  end

  // register, strobe and gate pins idle high after reset
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      st_q        <= '0;
      st_q.st     <= EDC_WAKE;
      st_q.ras_n  <= 1'b1;
      st_q.lower_byte_column_strobe_n_n <= 1'b1;
      st_q.upper_byte_column_strobe_n_n <= 1'b1;
      st_q.we_n   <= 1'b1;
      st_q.oe_n   <= 1'b1;
    end
    else
      st_q <= st_d;
  end
endmodule : edc_ctrl

// [pkg/edc_cfg.svh]
// timing and field constants of the edo page-mode dram controller
`ifndef EDC_CFG_SVH
`define EDC_CFG_SVH
`define EDC_CLK_NS        8
`define EDC_WAKE_US       200
`define EDC_WAKE_CYC      ((`EDC_WAKE_US * 1000) / `EDC_CLK_NS)
`define EDC_WAKE_REFS     4'h8
`define EDC_REF_MS        16
`define EDC_REF_ROWS      1024
`define EDC_REF_INT_CYC   (((`EDC_REF_MS * 1000000) / `EDC_REF_ROWS) / `EDC_CLK_NS)
`define EDC_T_RP_NS       40
`define EDC_T_RP_CYC      ((`EDC_T_RP_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_RAS_NS      60
`define EDC_T_RAS_CYC     ((`EDC_T_RAS_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_RCD_NS      14
`define EDC_T_RCD_CYC     ((`EDC_T_RCD_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_CAS_NS      15
`define EDC_T_CAS_CYC     ((`EDC_T_CAS_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_CP_NS       10
`define EDC_T_CP_CYC      ((`EDC_T_CP_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_T_CSR_NS      5
`define EDC_T_CSR_CYC     ((`EDC_T_CSR_NS + `EDC_CLK_NS - 1) / `EDC_CLK_NS)
`define EDC_CNT_W         16
`define EDC_ADDR_W        20
`define EDC_PIN_A_W       10
`define EDC_DATA_W        16
`define EDC_FIFO_DEPTH    8
`define EDC_ROW_LSB       10
`endif

// [pkg/edc_pkg.sv]
// types shared by the dram controller modules
`include "edc_cfg.svh"
package edc_pkg;
  typedef logic [`EDC_CNT_W-1:0]   edc_cnt_t;
  typedef logic [`EDC_ADDR_W-1:0]  edc_addr_t;
  typedef logic [`EDC_PIN_A_W-1:0] edc_pin_a_t;
  typedef logic [`EDC_DATA_W-1:0]  edc_data_t;
  // sequencer states
  typedef enum logic [3:0] {
    EDC_WAKE,
    EDC_IDLE,
    EDC_ROW,
    EDC_COL,
    EDC_CAS_HI,
    EDC_PRECH,
    EDC_CBR_SET,
    EDC_CBR_RAS
  } edc_state_t;
endpackage : edc_pkg

// [verilog/edc_fifo.sv]
// small flop fifo with valid and ready on both sides
`timescale 1ns/10ps
module edc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);
  // whole state in one struct
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
  } edc_fifo_st_t;
  edc_fifo_st_t st_q;
  edc_fifo_st_t st_d;
  logic push;
  logic pop;

  // handshake terms, full and empty straight from count
  assign in_ready  = (st_q.cnt != (AW+1)'(DEPTH));
  assign out_valid = (st_q.cnt != '0);
  assign out_data  = st_q.mem[st_q.rd];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // next state
  always_comb
  begin
    st_d = st_q;
    if (push)
    begin
      st_d.mem[st_q.wr] = in_data;
      st_d.wr = (st_q.wr == AW'(DEPTH-1)) ? '0 : st_q.wr + 1'b1;
    end
    if (pop)
      st_d.rd = (st_q.rd == AW'(DEPTH-1)) ? '0 : st_q.rd + 1'b1;
    st_d.cnt = st_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule : edc_fifo

// [verilog/edc_refresh_timer.sv]
// periodic refresh request timer, queues up to three owed refreshes, flags overrun
`timescale 1ns/10ps
`include "edc_cfg.svh"
module edc_refresh_timer
  import edc_pkg::*;
#(
  parameter int INTERVAL = `EDC_REF_INT_CYC
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic rst,
  // control
  input  wire logic run,
  input  wire logic ack,
  // status
  output logic      req,
  output logic      overrun
);
  // whole state in one struct
  typedef struct packed {
    edc_cnt_t   cnt;
    logic [1:0] pend;
    logic       ovr;
  } edc_rt_st_t;
  edc_rt_st_t st_q;
  edc_rt_st_t st_d;

  assign req     = (st_q.pend != 2'h0);
  assign overrun = st_q.ovr;

  // count interval, queue owed refreshes; ack counted before a new tick
  always_comb
  begin
    st_d = st_q;
    if (ack && st_q.pend != 2'h0)
      st_d.pend = st_q.pend - 2'h1;
    if (run)
    begin
      if (st_q.cnt == edc_cnt_t'(INTERVAL - 1))
      begin
        st_d.cnt = '0;
        // a fourth owed refresh means the period was overrun
        if (st_d.pend == 2'h3)
          st_d.ovr = 1'b1;
        else
          st_d.pend = st_d.pend + 2'h1;
      end
      else
        st_d.cnt = st_q.cnt + 1'b1;
    end
    else
    begin
      st_d.cnt  = '0;
      st_d.pend = 2'h0;
      st_d.ovr  = 1'b0;
    end
  end

  // register
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      st_q <= '0;
    else
      st_q <= st_d;
  end
endmodule : edc_refresh_timer

// [bench/edc_ctrl_chk.sv]
// pin-level assertions for the dram controller
`timescale 1ns/10ps
module edc_ctrl_chk #(
  parameter int WAKE_CYC = 20,
  parameter int REF_INT  = 200
) (
  // clock and reset
  input wire logic CLK_SYS,
  input wire logic SYS_RST,
  // request side
  input wire logic RD_VALID,
  input wire logic RD_READY,
  input wire logic RD_DONE,
  input wire logic INIT_DONE,
  // dram pins
  input wire logic ROW_STROBE_N,
  input wire logic LOWER_BYTE_COLUMN_STROBE_N,
  input wire logic UPPER_BYTE_COLUMN_STROBE_N,
  input wire logic WRITE_STROBE_N,
  input wire logic OUTPUT_GATE_N,
  input wire logic DQ_OE
);
  // short aliases keep the properties readable
  wire logic rs = ROW_STROBE_N;
  wire logic lc = LOWER_BYTE_COLUMN_STROBE_N;
  wire logic uc = UPPER_BYTE_COLUMN_STROBE_N;
  wire logic we = WRITE_STROBE_N;
  int unsigned cyc_q; // cycles since reset, saturates so it never wraps
  // cycle counter for the wake pause
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
      cyc_q <= 0;
    else if (cyc_q < 32'h0000ffff)
      cyc_q <= cyc_q + 1;
  int unsigned gap_q; // cycles since the last cbr row fall
  logic        rs_q;  // row strobe one cycle back
  // refresh spacing counter, cleared by each cbr row fall
  always_ff @(posedge CLK_SYS or posedge SYS_RST)
    if (SYS_RST)
    begin
      gap_q <= 0;
      rs_q  <= 1'b1;
    end
    else
    begin
      rs_q <= rs;
      if (rs_q && !rs && !lc)
        gap_q <= 0;
      else if (gap_q < 32'h0000ffff)
        gap_q <= gap_q + 1;
    end
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SYS_RST);
  // read request taken, then the answer
  sequence rd_take_s; RD_VALID && RD_READY; endsequence
  sequence rd_ans_s; ##[3:8] RD_DONE; endsequence
  wake_pause_a: assert property (
    $rose(INIT_DONE) |-> cyc_q >= WAKE_CYC + 64) else $error("init done too early");
  no_early_req_a: assert property (
    !INIT_DONE |-> !RD_READY) else $error("read taken before init");
  early_write_a: assert property (
    $fell(we) |-> $fell(lc) || $fell(uc) || (lc && uc)) else $error("write after cas");
  gate_in_write_a: assert property (
    !we |-> OUTPUT_GATE_N) else $error("gate low during write");
  drive_in_write_a: assert property (
    DQ_OE |-> !we && !rs) else $error("data driven outside write");
  cbr_order_a: assert property (
    $fell(rs) |-> (lc && uc) || $past(!lc || !uc)) else $error("bad row fall");
  lower_width_a: assert property (
    $fell(lc) |-> !lc [*2]) else $error("lower strobe too short");
  upper_width_a: assert property (
    $fell(uc) |-> !uc [*2]) else $error("upper strobe too short");
  row_prech_a: assert property (
    $rose(rs) |-> rs [*5]) else $error("row precharge too short");
  read_hold_a: assert property (
    rd_take_s |-> we throughout rd_ans_s) else $error("read answer late or write low");
  refresh_gap_a: assert property (
    INIT_DONE |-> gap_q < 2 * REF_INT) else $error("refresh gap too long");
endmodule : edc_ctrl_chk

bind edc_ctrl edc_ctrl_chk #(.WAKE_CYC(WAKE_CYC), .REF_INT(REF_INT)) u_chk (
  .CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .RD_VALID(RD_VALID), .RD_READY(RD_READY),
  .RD_DONE(RD_DONE), .INIT_DONE(INIT_DONE), .ROW_STROBE_N(ROW_STROBE_N),
  .LOWER_BYTE_COLUMN_STROBE_N(LOWER_BYTE_COLUMN_STROBE_N),
  .UPPER_BYTE_COLUMN_STROBE_N(UPPER_BYTE_COLUMN_STROBE_N),
  .WRITE_STROBE_N(WRITE_STROBE_N), .OUTPUT_GATE_N(OUTPUT_GATE_N), .DQ_OE(DQ_OE));

// [bench/edc_dram_model.sv]
// behavioural page-mode dram answering the controller pins
`timescale 1ns/10ps
module edc_dram_model
  import edc_pkg::*;
(
  // strobes, active low
  input  wire logic       ras_n,
  input  wire logic       lower_byte_column_strobe_n_n,
  input  wire logic       upper_byte_column_strobe_n_n,
  input  wire logic       we_n,
  input  wire logic       oe_n,
  // address and data
  input  wire edc_pin_a_t addr,
  input  wire edc_data_t  dq_in,
  output edc_data_t       dq_out,
  // counters for the bench
  output int              refreshes,
  output int              early_access
);
  // cells never decay, so self refresh needs no model
  edc_data_t  mem [edc_addr_t]; // sparse cell store
  edc_pin_a_t row_q;            // row latched at row fall
  edc_addr_t  a_q;              // selected cell
  edc_data_t  rd_q;             // cell seen by the outputs
  edc_data_t  last_q;           // last value driven
  logic       wr_q;             // current column access writes
  logic       drv_l;            // lower lane drives
  logic       drv_u;            // upper lane drives
  initial
  begin
    {refreshes, early_access} = '0;
    {row_q, a_q, rd_q, last_q, wr_q} = '0;
  end
  // refresh or row latch; refresh leaves output data alone
  always @(negedge ras_n)
  begin
    #1;
    if (!lower_byte_column_strobe_n_n || !upper_byte_column_strobe_n_n)
      refreshes++;
    else
      row_q = addr;
  end
  // per-lane column access, sampled after pins settle
  task automatic col(input int lane);
    edc_data_t w;
    #1;
    if (ras_n)
      return;
    a_q = {row_q, addr};
    if (refreshes < 8)
      early_access++;
    w = mem.exists(a_q) ? mem[a_q] : ~a_q[15:0];
    wr_q = !we_n;
    if (!we_n)
      w[lane*8 +: 8] = dq_in[lane*8 +: 8];
    mem[a_q] = w;
    rd_q = w;
  endtask : col
  always @(negedge lower_byte_column_strobe_n_n) col(0);
  always @(negedge upper_byte_column_strobe_n_n) col(1);
  assign drv_l = !lower_byte_column_strobe_n_n && !oe_n && we_n && !wr_q;
  assign drv_u = !upper_byte_column_strobe_n_n && !oe_n && we_n && !wr_q;
  // a released lane shows the inverse, so a stale value never passes
  always @(drv_l or drv_u or rd_q)
  begin
    if (drv_l)
      last_q[7:0] = rd_q[7:0];
    if (drv_u)
      last_q[15:8] = rd_q[15:8];
  end
  assign dq_out = {drv_u ? rd_q[15:8] : ~last_q[15:8], drv_l ? rd_q[7:0] : ~last_q[7:0]};
endmodule : edc_dram_model

// [bench/edc_ctrl_bench.sv]
// self-checking bench for the dram controller
`timescale 1ns/10ps
`define EDC_CHECK(what, exp, got) begin checks_done++; if ((got) !== (exp)) begin fails++; \
  $display("Error %s expected %h seen %h", what, exp, got); end end
module edc_ctrl_bench;
  import edc_pkg::*;
  localparam int RINT = 200; // shortened refresh interval
  logic clk, rst, wr_valid, rd_valid, wr_ready, rd_ready, rd_done, init_done, dq_oe;
  logic ras_n, lower_byte_column_strobe_n_n, upper_byte_column_strobe_n_n, we_n, oe_n;
  logic [1:0] wr_be;
  edc_addr_t wr_addr, rd_addr;
  edc_data_t wr_data, rd_data, dq_o, dq_i, dq_mod;
  edc_pin_a_t addr;
  int fails, checks_done, refs, early, seen_full, r0;
  edc_data_t exp_mem [edc_addr_t]; // expected cell contents
  edc_addr_t pool [12];            // addresses in use
  // data wire: controller while it drives, else the dram
  assign dq_i = dq_oe ? dq_o : dq_mod;
  edc_ctrl #(.WAKE_CYC(20), .REF_INT(RINT)) DUT (
    .CLK_SYS(clk), .SYS_RST(rst), .WR_VALID(wr_valid), .WR_READY(wr_ready),
    .WR_ADDR(wr_addr), .WR_DATA(wr_data), .WR_BE(wr_be), .RD_VALID(rd_valid),
    .RD_READY(rd_ready), .RD_ADDR(rd_addr), .RD_DONE(rd_done), .RD_DATA(rd_data),
    .INIT_DONE(init_done), .ROW_STROBE_N(ras_n), .LOWER_BYTE_COLUMN_STROBE_N(lower_byte_column_strobe_n_n),
    .UPPER_BYTE_COLUMN_STROBE_N(upper_byte_column_strobe_n_n), .WRITE_STROBE_N(we_n), .OUTPUT_GATE_N(oe_n),
    .MULTIPLEXED_ADDRESS_PINS(addr), .DQ_I(dq_i), .DQ_O(dq_o), .DQ_OE(dq_oe));
  edc_dram_model u_mem (
    .ras_n(ras_n), .lower_byte_column_strobe_n_n(lower_byte_column_strobe_n_n), .upper_byte_column_strobe_n_n(upper_byte_column_strobe_n_n), .we_n(we_n), .oe_n(oe_n),
    .addr(addr), .dq_in(dq_i), .dq_out(dq_mod), .refreshes(refs), .early_access(early));
  // free-running clock
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // closing verdict
  task automatic print_verdict();
    if (fails == 0 && checks_done > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : print_verdict
  // byte-lane merge of a write into a cell
  function automatic edc_data_t merge(edc_data_t old, edc_data_t nw, logic [1:0] be);
    return {be[1] ? nw[15:8] : old[15:8], be[0] ? nw[7:0] : old[7:0]};
  endfunction : merge
  // wait for a level at a falling edge, bounded
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    while (s !== 1'b1 && n < 3000)
    begin
      n++;
      @(negedge clk);
    end
    if (n >= 3000)
    begin
      fails++;
      $display("Error level wait expected 1 seen %b", s);
    end
  endtask : wait_hi
  // write push; valid stays up so pushes run back to back
  task automatic wr(edc_addr_t a, edc_data_t d, logic [1:0] be);
    wr_valid = 1'b1;
    {wr_addr, wr_data, wr_be} = {a, d, be};
    if (!wr_ready)
      seen_full = 1;
    wait_hi(wr_ready);
    @(negedge clk);
    exp_mem[a] = merge(exp_mem.exists(a) ? exp_mem[a] : ~a[15:0], d, be);
  endtask : wr
  // read and compare
  task automatic rd(edc_addr_t a);
    rd_valid = 1'b1;
    rd_addr = a;
    wait_hi(rd_ready);
    @(negedge clk);
    rd_valid = 1'b0;
    wait_hi(rd_done);
    `EDC_CHECK("read data", exp_mem[a], rd_data)
  endtask : rd
  // watchdog
  initial
  begin
    repeat (60000) @(posedge clk);
    fails++;
    $display("Error watchdog expected finish seen timeout");
    print_verdict();
  end
  initial
  begin
    void'($urandom(32'h9398));
    {wr_valid, rd_valid, wr_be, wr_addr, rd_addr, wr_data} = '0;
    {fails, checks_done, seen_full} = '0;
    rst = 1'b1;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    // a read asked for during wake-up must stay refused
    rd_valid = 1'b1;
    repeat (5) @(negedge clk);
    `EDC_CHECK("read refused", 1'b0, rd_ready)
    rd_valid = 1'b0;
    wait_hi(init_done);
    `EDC_CHECK("wake refreshes", 1'b1, refs >= 8)
    `EDC_CHECK("access before wake", 0, early)
    // corner rows and columns, then random ones
    pool[0:3] = '{20'h00000, 20'hfffff, 20'h003ff, 20'hffc00};
    for (int i = 4; i < 12; i++)
      pool[i] = edc_addr_t'($urandom);
    // full words back to back overrun the fifo
    for (int i = 0; i < 12; i++)
      wr(pool[i], edc_data_t'($urandom), 2'b11);
    // random lanes, none included
    for (int i = 0; i < 24; i++)
      wr(pool[$urandom % 12], edc_data_t'($urandom), 2'($urandom));
    wr_valid = 1'b0;
    repeat (400) @(negedge clk);
    `EDC_CHECK("fifo refused", 1, seen_full)
    foreach (pool[i])
      rd(pool[i]);
    r0 = refs;
    repeat (10 * RINT) @(negedge clk);
    `EDC_CHECK("refresh rate", 1'b1, refs - r0 >= 9)
    `EDC_CHECK("no overrun", 1'b1, init_done)
    // second reset in mid-run
    rst = 1'b1;
    @(negedge clk);
    `EDC_CHECK("idle pins", 6'h3f, {ras_n, lower_byte_column_strobe_n_n, upper_byte_column_strobe_n_n, we_n, oe_n, !dq_oe})
    r0 = refs;
    rst = 1'b0;
    @(negedge clk);
    wait_hi(init_done);
    `EDC_CHECK("rewake refreshes", 1'b1, refs - r0 >= 8)
    rd(pool[1]);
    print_verdict();
  end
endmodule : edc_ctrl_bench
